// ---- design/sense_adc_gain_trim.sv ----
// Gain trim of three voltage-sense readings, with an AXI4-Lite register slave.
// Assumes raw ADC codes and their valid strobes are synchronous to clk_i.
//
// Operation
// - Trim bit 7 set gives negative correction, clear gives positive correction.
// - Channel a reading is scaled by a correction sized by its trim bits 6..0.
// - Channel b reading is scaled by a correction sized by its trim bits 6..0.
// - Channel c reading is scaled by a correction sized by its trim bits 6..0.
`default_nettype none

module sense_adc_gain_trim
  import sense_trim_pkg::*;
#(
  parameter int ADC_W      = ADC_W_DEF,
  parameter int TRIM_SHIFT = SHIFT_DEF
)
(
  input  wire logic                   clk_i,
  input  wire logic                   reset_i,
  input  wire axi_lite_req_t          req_i,
  output var  axi_lite_rsp_t          rsp_o,
  input  wire logic [2:0][ADC_W-1:0]  sense_raw_i,
  input  wire logic [2:0]             sample_valid_i,
  output var  logic [2:0][ADC_W-1:0]  sense_value_o,
  output var  logic [2:0]             value_update_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  // A shift of seven or more keeps the correction below the raw code,
  // so the negative path never wraps and only the positive path saturates.
  if (ADC_W < 8 || ADC_W > 24)
  begin : g_bad_width
    $error("ADC_W must lie between 8 and 24");
  end
  if (TRIM_SHIFT < 7 || TRIM_SHIFT > 16)
  begin : g_bad_shift
    $error("TRIM_SHIFT must lie between 7 and 16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [2:0][7:0]       trim;
    logic [7:0]            llcfg;
    logic [2:0][ADC_W-1:0] value;
    logic [2:0]            fresh;
    wr_state_t             wr;
    logic [1:0]            bresp;
    rd_state_t             rd;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } state_t;

  state_t            s;
  state_t            next_s;
  logic              aw_take;
  logic              ar_take;
  logic [7:0]        wr_idx;
  logic [7:0]        rd_idx;

  ////////////////////////////////////////////////////////////////////////////
  // Functions
  function automatic logic [ADC_W-1:0] trim_apply(input logic [ADC_W-1:0] raw,
                                                   input logic [7:0]       trim);
    logic [ADC_W+6:0] prod;
    logic [ADC_W-1:0] corr;
    logic [ADC_W:0]   sum;
    prod = (ADC_W+7)'(raw) * (ADC_W+7)'(trim[TRIM_MAG_MSB:0]);
    corr = ADC_W'(prod >> TRIM_SHIFT);
    sum  = {1'b0, raw} + {1'b0, corr};
    if (trim[TRIM_POL_BIT])
      trim_apply = raw - corr;
    else if (sum[ADC_W])
      trim_apply = '1;
    else
      trim_apply = sum[ADC_W-1:0];
  endfunction

  // Address bits above the index must be zero, else the access is unmapped
  function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] addr);
    if (addr[ADDR_W-1:10] != '0)
      word_index = 8'hff;
    else
      word_index = addr[9:2];
  endfunction

  function automatic logic is_writable(input logic [7:0] idx);
    is_writable = (idx == IDX_TRIM_A) || (idx == IDX_TRIM_B) ||
                  (idx == IDX_TRIM_C) || (idx == IDX_LLCFG);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Handshakes
  // Address and data are taken together; the master offers both at once.
  assign wr_idx  = word_index(req_i.awaddr);
  assign rd_idx  = word_index(req_i.araddr);
  assign aw_take = (s.wr == WR_IDLE) && req_i.awvalid && req_i.wvalid;
  assign ar_take = (s.rd == RD_IDLE) && req_i.arvalid;

  always_comb
  begin
    rsp_o.awready  = aw_take;
    rsp_o.wready   = aw_take;
    rsp_o.bvalid   = (s.wr == WR_RESP);
    rsp_o.bresp    = s.bresp;
    rsp_o.arready  = (s.rd == RD_IDLE);
    rsp_o.rvalid   = (s.rd == RD_DATA);
    rsp_o.rdata    = s.rdata;
    rsp_o.rresp    = s.rresp;
    sense_value_o  = s.value;
    value_update_o = s.fresh;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    next_s       = s;
    next_s.fresh = 3'h0;
    for (int i = 0; i < 3; i++)
    begin
      if (sample_valid_i[i])
      begin
        next_s.value[i] = trim_apply(sense_raw_i[i], s.trim[i]);
        next_s.fresh[i] = 1'b1;
      end
    end

    case (s.wr)
      WR_IDLE:
      begin
        if (aw_take)
        begin
          next_s.wr    = WR_RESP;
          next_s.bresp = is_writable(wr_idx) ? RESP_OKAY : RESP_SLVERR;
          if (req_i.wstrb[0])
          begin
            case (wr_idx)
              IDX_TRIM_A: next_s.trim[0] = req_i.wdata[7:0];
              IDX_TRIM_B: next_s.trim[1] = req_i.wdata[7:0];
              IDX_TRIM_C: next_s.trim[2] = req_i.wdata[7:0];
              IDX_LLCFG:  next_s.llcfg   = req_i.wdata[7:0];
              default:    next_s.llcfg   = s.llcfg;
            endcase
          end
        end
      end
      WR_RESP:
      begin
        if (req_i.bready)
          next_s.wr = WR_IDLE;
      end
      default:
      begin
        next_s.wr = WR_IDLE;
      end
    endcase

    case (s.rd)
      RD_IDLE:
      begin
        if (ar_take)
        begin
          next_s.rd    = RD_DATA;
          next_s.rresp = RESP_OKAY;
          // Value registers show the trimmed reading software calibrates against
          case (rd_idx)
            IDX_VALUE_A: next_s.rdata = 32'(s.value[0]);
            IDX_VALUE_B: next_s.rdata = 32'(s.value[1]);
            IDX_VALUE_C: next_s.rdata = 32'(s.value[2]);
            IDX_TRIM_A:  next_s.rdata = 32'(s.trim[0]);
            IDX_TRIM_B:  next_s.rdata = 32'(s.trim[1]);
            IDX_TRIM_C:  next_s.rdata = 32'(s.trim[2]);
            IDX_LLCFG:   next_s.rdata = 32'(s.llcfg);
            default:
            begin
              next_s.rdata = 32'h0000_0000;
              next_s.rresp = RESP_SLVERR;
            end
          endcase
        end
      end
      RD_DATA:
      begin
        if (req_i.rready)
          next_s.rd = RD_IDLE;
      end
      default:
      begin
        next_s.rd = RD_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      s       <= '0;
      s.trim  <= {3{TRIM_RESET}};
      s.llcfg <= LLCFG_RESET;
      s.wr    <= WR_IDLE;
      s.rd    <= RD_IDLE;
    end
    else
    begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_write_taken;
    req_i.awvalid && req_i.wvalid && rsp_o.awready;
  endsequence

  sequence s_write_answered;
    rsp_o.bvalid ##0 rsp_o.bresp == (is_writable($past(wr_idx)) ? RESP_OKAY : RESP_SLVERR);
  endsequence

  sequence s_read_taken;
    req_i.arvalid && rsp_o.arready;
  endsequence

  property p_write_answer;
    s_write_taken |=> s_write_answered;
  endproperty

  property p_read_answer;
    s_read_taken |=> rsp_o.rvalid && !rsp_o.arready;
  endproperty

  a_write_answer: assert property (p_write_answer)
    else $error("write response missing or wrong");

  a_read_answer: assert property (p_read_answer)
    else $error("read response missing");

  a_bvalid_hold: assert property (rsp_o.bvalid && !req_i.bready |=> rsp_o.bvalid && $stable(rsp_o.bresp))
    else $error("write response dropped early");

  a_trim_write_a: assert property (
    s_write_taken ##0 (wr_idx == IDX_TRIM_A) && req_i.wstrb[0] |=> s.trim[0] == $past(req_i.wdata[7:0]))
    else $error("channel a trim not written");

  a_trim_write_b: assert property (
    s_write_taken ##0 (wr_idx == IDX_TRIM_B) && req_i.wstrb[0] |=> s.trim[1] == $past(req_i.wdata[7:0]))
    else $error("channel b trim not written");

  a_trim_write_c: assert property (
    s_write_taken ##0 (wr_idx == IDX_TRIM_C) && req_i.wstrb[0] |=> s.trim[2] == $past(req_i.wdata[7:0]))
    else $error("channel c trim not written");

  a_read_trim_c: assert property (
    s_read_taken ##0 (rd_idx == IDX_TRIM_C) |=> rsp_o.rdata == 32'($past(s.trim[2])))
    else $error("channel c trim read back wrong");

  a_negative_pol: assert property (
    sample_valid_i[0] && s.trim[0][TRIM_POL_BIT] |=> sense_value_o[0] <= $past(sense_raw_i[0]))
    else $error("negative trim raised the reading");

  a_positive_pol: assert property (
    sample_valid_i[1] && !s.trim[1][TRIM_POL_BIT] |=> sense_value_o[1] >= $past(sense_raw_i[1]))
    else $error("positive trim lowered the reading");

  a_zero_trim_a: assert property (
    sample_valid_i[0] && s.trim[0][TRIM_MAG_MSB:0] == 7'h00
    |=> sense_value_o[0] == $past(sense_raw_i[0]) && value_update_o[0])
    else $error("zero trim altered channel a");

  a_zero_trim_b: assert property (
    sample_valid_i[1] && s.trim[1][TRIM_MAG_MSB:0] == 7'h00 |=> sense_value_o[1] == $past(sense_raw_i[1]))
    else $error("zero trim altered channel b");

  a_zero_trim_c: assert property (
    sample_valid_i[2] && s.trim[2][TRIM_MAG_MSB:0] == 7'h00
    |=> sense_value_o[2] == $past(sense_raw_i[2]) && value_update_o[2])
    else $error("zero trim altered channel c");

  // Full scale with positive trim must pin at full scale rather than wrap to a low reading
  a_saturate_b: assert property (
    sample_valid_i[1] && !s.trim[1][TRIM_POL_BIT] && sense_raw_i[1] == '1 |=> sense_value_o[1] == '1)
    else $error("positive trim wrapped channel b");

  // Codes below one trim step get no correction, so the check starts where a step exists
  a_full_trim_c: assert property (
    sample_valid_i[2] && s.trim[2] == 8'hff && int'(sense_raw_i[2]) >= (1 << (TRIM_SHIFT - 6))
    |=> sense_value_o[2] < $past(sense_raw_i[2]))
    else $error("full negative trim left channel c unchanged");

  a_value_hold_a: assert property (
    !sample_valid_i[0] |=> $stable(sense_value_o[0]) && !value_update_o[0])
    else $error("channel a value changed without a sample");

  a_value_hold_b: assert property (
    !sample_valid_i[1] |=> $stable(sense_value_o[1]) && !value_update_o[1])
    else $error("channel b value changed without a sample");

  a_value_hold: assert property (
    !sample_valid_i[2] |=> $stable(sense_value_o[2]) && !value_update_o[2])
    else $error("channel c value changed without a sample");

endmodule

`default_nettype wire

// ---- design/sense_trim_pkg.sv ----
// Constants, bus carriers and state codes for the sense gain trim block.
// Assumes a single system clock and an AXI4-Lite master with 32-bit data.
`default_nettype none

package sense_trim_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_VALUE_A = 8'h15;
  localparam logic [7:0] IDX_VALUE_B = 8'h16;
  localparam logic [7:0] IDX_VALUE_C = 8'h17;
  localparam logic [7:0] IDX_TRIM_A  = 8'h38;
  localparam logic [7:0] IDX_TRIM_B  = 8'h39;
  localparam logic [7:0] IDX_TRIM_C  = 8'h3a;
  localparam logic [7:0] IDX_LLCFG   = 8'h3b;

  ////////////////////////////////////////////////////////////////////////////
  // Fields and reset values
  localparam int         TRIM_POL_BIT = 7;
  localparam int         TRIM_MAG_MSB = 6;
  localparam logic [7:0] TRIM_RESET   = 8'h00;
  localparam logic [7:0] LLCFG_RESET  = 8'h00;
  localparam int         ADC_W_DEF    = 12;
  localparam int         SHIFT_DEF    = 10;
  // Reading that software aims for with 1 V on a sense pin
  localparam logic [11:0] CAL_TARGET  = 12'ha53;

  ////////////////////////////////////////////////////////////////////////////
  // Bus
  localparam int         ADDR_W      = 12;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } axi_lite_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_lite_rsp_t;

  typedef enum logic [1:0] {WR_IDLE = 2'h1, WR_RESP = 2'h2} wr_state_t;
  typedef enum logic [1:0] {RD_IDLE = 2'h1, RD_DATA = 2'h2} rd_state_t;

endpackage

`default_nettype wire

// ---- verif/test_sense_adc_gain_trim.sv ----
// Self-checking bench for the sense gain trim block.
// Assumes the default widths (12-bit codes, shift 10) and the AXI4-Lite map of the package.
`default_nettype none

module test_sense_adc_gain_trim;
  import sense_trim_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {string what; logic [33:0] v;} note_t;

  logic                clk_i          = 1'b0;
  logic                reset_i        = 1'b1;
  axi_lite_req_t       req            = '0;
  axi_lite_rsp_t       rsp;
  logic [2:0][11:0]    sense_raw_i    = '0;
  logic [2:0]          sample_valid_i = '0;
  logic [2:0][11:0]    sense_value_o;
  logic [2:0]          value_update_o;
  note_t               notes[$];
  logic [7:0]          trim[3]        = '{8'h00, 8'h00, 8'h00};
  logic [11:0]         last[3]        = '{12'h000, 12'h000, 12'h000};
  logic [7:0]          tab[5]         = '{8'h00, 8'h7f, 8'hff, 8'h80, 8'h00};
  // Trim and raw code pairs that land on the calibration target with shift 10
  logic [7:0]          cal_trim[3]    = '{8'h00, 8'h88, 8'h08};
  logic [11:0]         cal_raw[3]     = '{12'ha53, 12'ha67, 12'ha3f};
  int                  mismatches     = 0;
  int                  samples_checked = 0;
  int                  cycles         = 0;
  int                  seed           = 32'h1dc1;

  sense_adc_gain_trim i_dut
  (
    .clk_i          (clk_i),
    .reset_i        (reset_i),
    .req_i          (req),
    .rsp_o          (rsp),
    .sense_raw_i    (sense_raw_i),
    .sample_valid_i (sample_valid_i),
    .sense_value_o  (sense_value_o),
    .value_update_o (value_update_o)
  );

  initial
  begin
    forever #10 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference trim; saturates high so a large raw code cannot wrap to a low reading
  function automatic logic [11:0] trimmed(input logic [11:0] raw, input logic [7:0] t);
    logic [19:0] c;
    logic [12:0] s;
    c = ({8'h00, raw} * {13'h0000, t[6:0]}) >> 10;
    s = {1'b0, raw} + {1'b0, c[11:0]};
    if (t[7])
      return raw - c[11:0];
    return s[12] ? 12'hfff : s[11:0];
  endfunction

  task automatic print_verdict();
    if (mismatches == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [33:0] seen);
    note_t n;
    begin
      samples_checked++;
      if (notes.size() == 0)
      begin
        mismatches++;
        $display("wrong value %s: expected none, seen %h", what, seen);
      end
      else
      begin
        n = notes.pop_front();
        if (n.v !== seen)
        begin
          mismatches++;
          $display("wrong value %s: expected %h, seen %h", n.what, n.v, seen);
        end
      end
    end
  endtask

  // One result in flight at a time, so arrival order equals request order
  always @(posedge clk_i)
  begin
    if (rsp.bvalid === 1'b1 && req.bready === 1'b1)
      check("bresp", {32'h0, rsp.bresp});
    if (rsp.rvalid === 1'b1 && req.rready === 1'b1)
      check("read", {rsp.rresp, rsp.rdata});
    for (int i = 0; i < 3; i++)
      if (value_update_o[i] === 1'b1)
        check("sense value", {22'h0, sense_value_o[i]});
  end

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus master and sample tasks; each starts just after a rising edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
    notes.push_back('{"bresp", {32'h0, e}});
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    req.awaddr  <= a;
    req.wdata   <= d;
    req.wstrb   <= s;
    req.bready  <= 1'b1;
    do @(posedge clk_i); while (rsp.awready !== 1'b1 || rsp.wready !== 1'b1);
    req.awvalid <= 1'b0;
    req.wvalid  <= 1'b0;
    do @(posedge clk_i); while (rsp.bvalid !== 1'b1);
    req.bready  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    notes.push_back('{"read", e});
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do @(posedge clk_i); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge clk_i); while (rsp.rvalid !== 1'b1);
    req.rready  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic smp(input int ch, input logic [11:0] raw);
    last[ch] = trimmed(raw, trim[ch]);
    notes.push_back('{"sense value", {22'h0, last[ch]}});
    sample_valid_i[ch] <= 1'b1;
    sense_raw_i[ch]    <= raw;
    @(posedge clk_i);
    sample_valid_i[ch] <= 1'b0;
    sense_raw_i[ch]    <= ~raw;
    repeat (2) @(posedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    for (int a = 0; a < 4; a++)
      rd(12'h0e0 + 12'(4 * a), {RESP_OKAY, 32'h0});
    for (int a = 0; a < 3; a++)
      rd(12'h054 + 12'(4 * a), {RESP_OKAY, 32'h0});
    for (int ch = 0; ch < 3; ch++)
      for (int k = 0; k < 5; k++)
      begin
        trim[ch] = (k == 4) ? 8'($random(seed)) : tab[k];
        wr(12'h0e0 + 12'(4 * ch), {24'($random(seed)), trim[ch]}, 4'hf, RESP_OKAY);
        rd(12'h0e0 + 12'(4 * ch), {RESP_OKAY, 24'h0, trim[ch]});
        smp(ch, 12'($random(seed)));
        smp(ch, 12'hfff);
        smp(ch, 12'ha53);
        rd(12'h054 + 12'(4 * ch), {RESP_OKAY, 20'h0, last[ch]});
      end
    wr(12'h054, 32'h0000_0fff, 4'hf, RESP_SLVERR);
    rd(12'h054, {RESP_OKAY, 20'h0, last[0]});
    wr(12'h0e0, 32'h0000_0055, 4'he, RESP_OKAY);
    rd(12'h0e0, {RESP_OKAY, 24'h0, trim[0]});
    wr(12'h0ec, 32'h0000_00a5, 4'hf, RESP_OKAY);
    rd(12'h0ec, {RESP_OKAY, 32'h0000_00a5});
    wr(12'hc00, 32'h0000_0011, 4'hf, RESP_SLVERR);
    rd(12'h800, {RESP_SLVERR, 32'h0});
    // Calibration in channel order, channel c last
    for (int ch = 0; ch < 3; ch++)
    begin
      trim[ch] = cal_trim[ch];
      wr(12'h0e0 + 12'(4 * ch), {24'h0, cal_trim[ch]}, 4'hf, RESP_OKAY);
      smp(ch, cal_raw[ch]);
      rd(12'h054 + 12'(4 * ch), {RESP_OKAY, 20'h0, CAL_TARGET});
    end
    // Reset in mid-run must bring channel c trim and value and the light-load setting back
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rd(12'h0e8, {RESP_OKAY, 24'h0, TRIM_RESET});
    rd(12'h05c, {RESP_OKAY, 32'h0});
    rd(12'h0ec, {RESP_OKAY, 24'h0, LLCFG_RESET});
    repeat (4) @(posedge clk_i);
    if (notes.size() != 0)
    begin
      mismatches++;
      $display("wrong value pending results: expected 0, seen %0d", notes.size());
    end
    print_verdict();
  end

endmodule

`default_nettype wire
